/* File: design/amtx_pkg.sv */
// Package with constants shared by the alternate medium port block
package amtx_pkg;
  // Width of the current transmit state field
  localparam int unsigned STATE_W = 3;
  // Code of the state field that means the transmitter is switched off
  localparam logic [STATE_W-1:0] OFF_TX_CODE = 3'h0;
  // Stages in each pin synchroniser
  localparam int unsigned SYNC_STAGES = 2;
  // Reset values of gated outputs and captured data
  localparam logic OUT_RST = 1'h0;
  localparam logic OE_RST  = 1'h0;
  // Link bit clock figure, for reference only
  localparam int unsigned LINK_MHZ = 125;

  // Alternate receive path sequencing
  typedef enum logic [1:0] {
    AMTX_ALT_OFF = 2'b00,
    AMTX_ALT_ARM = 2'b01,
    AMTX_ALT_RUN = 2'b10
  } amtx_alt_state_t;
endpackage

/* File: design/amtx_port.sv */
// Alternate medium port gating and medium driver enable logic
// What this block does
// - Recovered clock driven only when alternate enabled
// - Recovered data driven only when alternate enabled
// - External receive inputs feed core only when enabled
// - Transmit bit clock driven only when gated on
// - Enable bit low: driver enable inverts polarity
// - Off-transmit state: driver enable inverts polarity
// - Otherwise driver enable follows polarity input
`timescale 1ns/1ps
module amtx_port (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     alt_medium_enable_bit,
  input  wire logic                     tx_bitclock_gate_bit,
  input  wire logic                     transmit_enable_bit,
  input  wire logic [amtx_pkg::STATE_W-1:0] current_transmit_state_field,
  input  wire logic                     driver_enable_polarity_in,
  input  wire logic                     recovered_clock_src,
  input  wire logic                     recovered_data_src,
  input  wire logic                     serial_rx_data_in,
  input  wire logic                     serial_rx_strobe_in,
  input  wire logic                     tx_bit_clock_src,
  input  wire logic                     ext_rx_clock_in,
  input  wire logic                     ext_rx_data_in,
  output logic                          recovered_clock_out,
  output logic                          recovered_clock_oe,
  output logic                          recovered_data_out,
  output logic                          recovered_data_oe,
  output logic                          tx_bit_clock_out,
  output logic                          tx_bit_clock_oe,
  output logic                          medium_driver_enable_out,
  output logic                          core_rx_data,
  output logic                          core_rx_valid,
  output logic                          alt_path_running
);
  import amtx_pkg::*;

  logic            ext_clk_s;
  logic            ext_data_s;
  logic            pol_s;
  logic            ext_clk_d_ff;
  logic            ext_rise;
  logic            off_transmit_state;
  amtx_alt_state_t alt_state_ff;
  amtx_alt_state_t nxt_alt_state;
  logic            pol_raw_s;
  logic [2:0]      link_sync;

  // Link clock and data share one synchroniser so their skew stays equal
  amtx_sync #(
    .WIDTH (3)
  ) u_link_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({driver_enable_polarity_in, ext_rx_data_in, ext_rx_clock_in}),
    .sync_out (link_sync)
  );

  assign ext_clk_s  = link_sync[0];
  assign ext_data_s = link_sync[1];
  assign pol_raw_s  = link_sync[2];
  assign pol_s      = pol_raw_s;

  // Edge finder on the synchronised link clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_clk_d_ff <= OUT_RST;
    end else begin
      ext_clk_d_ff <= ext_clk_s;
    end
  end

  // Data taken on link clock rise
  assign ext_rise = ext_clk_s & ~ext_clk_d_ff;

  // Alternate path sequencing: wait for a clean edge before using data
  always_comb begin
    nxt_alt_state = alt_state_ff;
    case (alt_state_ff)
      AMTX_ALT_OFF: begin
        if (alt_medium_enable_bit) begin
          nxt_alt_state = AMTX_ALT_ARM;
        end
      end
      AMTX_ALT_ARM: begin
        if (!alt_medium_enable_bit) begin
          nxt_alt_state = AMTX_ALT_OFF;
        end else if (ext_rise) begin
          nxt_alt_state = AMTX_ALT_RUN;
        end
      end
      AMTX_ALT_RUN: begin
        if (!alt_medium_enable_bit) begin
          nxt_alt_state = AMTX_ALT_OFF;
        end
      end
      default: begin
        nxt_alt_state = AMTX_ALT_OFF;
      end
    endcase
  end

  // State register of the alternate path
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alt_state_ff <= AMTX_ALT_OFF;
    end else begin
      alt_state_ff <= nxt_alt_state;
    end
  end

  assign alt_path_running = (alt_state_ff == AMTX_ALT_RUN);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      recovered_clock_out <= OUT_RST;
      recovered_clock_oe  <= OE_RST;
    end else begin
      recovered_clock_out <= alt_medium_enable_bit & recovered_clock_src;
      recovered_clock_oe  <= alt_medium_enable_bit;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      recovered_data_out <= OUT_RST;
      recovered_data_oe  <= OE_RST;
    end else begin
      recovered_data_out <= alt_medium_enable_bit & recovered_data_src;
      recovered_data_oe  <= alt_medium_enable_bit;
    end
  end

  // Core input select
  // The first partial link bit after enabling is dropped, not forwarded
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_rx_data  <= OUT_RST;
      core_rx_valid <= OUT_RST;
    end else if (alt_medium_enable_bit) begin
      core_rx_valid <= alt_path_running & ext_rise;
      if (alt_path_running && ext_rise) begin
        core_rx_data <= ext_data_s;
      end
    end else begin
      core_rx_valid <= serial_rx_strobe_in;
      if (serial_rx_strobe_in) begin
        core_rx_data <= serial_rx_data_in;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_bit_clock_out <= OUT_RST;
      tx_bit_clock_oe  <= OE_RST;
    end else begin
      tx_bit_clock_out <= tx_bitclock_gate_bit & tx_bit_clock_src;
      tx_bit_clock_oe  <= tx_bitclock_gate_bit;
    end
  end

  assign off_transmit_state = (current_transmit_state_field == OFF_TX_CODE);

  // Driver enable level, three flops after the pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      medium_driver_enable_out <= OUT_RST;
    end else if (transmit_enable_bit && !off_transmit_state) begin
      medium_driver_enable_out <= pol_s;
    end else begin
      medium_driver_enable_out <= ~pol_s;
    end
  end

  // Checks, all on the core clock
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence link_rise_s;
    !ext_clk_s ##1 ext_clk_s;
  endsequence

  sequence alt_armed_s;
    alt_medium_enable_bit && alt_state_ff == AMTX_ALT_ARM;
  endsequence

  rec_clock_gate_a: assert property (
    recovered_clock_oe == $past(alt_medium_enable_bit) &&
    recovered_clock_out == ($past(alt_medium_enable_bit) & $past(recovered_clock_src)))
    else $error("recovered clock not gated by enable");

  rec_data_gate_a: assert property (
    !alt_medium_enable_bit [*2] |-> !recovered_data_oe && !recovered_data_out)
    else $error("recovered data driven while disabled");

  rec_data_pass_a: assert property (
    alt_medium_enable_bit |=> recovered_data_oe && recovered_data_out == $past(recovered_data_src))
    else $error("recovered data not passed while enabled");

  ext_ignored_a: assert property (
    !alt_medium_enable_bit |=> core_rx_valid == $past(serial_rx_strobe_in))
    else $error("external input used while disabled");

  ext_capture_a: assert property (
    alt_path_running && alt_medium_enable_bit && ext_rise |=>
      core_rx_valid && core_rx_data == $past(ext_data_s))
    else $error("external bit not captured on link clock rise");

  arm_to_run_a: assert property (
    alt_armed_s ##0 link_rise_s |=> alt_path_running || !$past(alt_medium_enable_bit))
    else $error("alternate path did not start on link edge");

  txc_gate_a: assert property (
    tx_bit_clock_oe == $past(tx_bitclock_gate_bit) && (!tx_bit_clock_oe -> !tx_bit_clock_out))
    else $error("transmit clock not gated by its bit");

  txe_disabled_a: assert property (
    !transmit_enable_bit |=> medium_driver_enable_out == !$past(pol_s))
    else $error("driver enable not inverted while transmit disabled");

  txe_off_state_a: assert property (
    transmit_enable_bit && current_transmit_state_field == OFF_TX_CODE |=>
      medium_driver_enable_out != $past(pol_s))
    else $error("driver enable not inverted in off-transmit state");

  txe_active_a: assert property (
    transmit_enable_bit && current_transmit_state_field != OFF_TX_CODE |=>
      medium_driver_enable_out == $past(pol_s))
    else $error("driver enable not following polarity input");

  // Disabled path must fall back to idle whatever the internal strobe does
  state_legal_a: assert property (
    !alt_medium_enable_bit |=> alt_state_ff == AMTX_ALT_OFF && !alt_path_running)
    else $error("alternate path state left on while disabled");

endmodule // amtx_port

/* File: design/amtx_sync.sv */
// Two flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module amtx_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import amtx_pkg::*;

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage is read only by the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // amtx_sync

/* File: test/amtx_pmd_model.sv */
// Behavioural medium transceiver driving the external receive pins
`timescale 1ns/1ps
module amtx_pmd_model (
  output logic link_clock,
  output logic link_data
);
  // Clock stands low between frames
  initial begin
    link_clock = 1'h0;
    link_data  = 1'h0;
  end
  task automatic send(input logic [8:0] bits);
    for (int i = 8; i >= 0; i--) begin
      link_data = bits[i];
      #40;
      link_clock = 1'h1;
      #40;
      link_clock = 1'h0;
    end
    // Released line shows the inverse, never a stale copy
    link_data = ~bits[0];
  endtask
endmodule // amtx_pmd_model

/* File: test/amtx_port_tb.sv */
// Self-checking bench for the alternate medium port block
`timescale 1ns/1ps
module amtx_port_tb;
  import amtx_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic alt = 1'h0, gate = 1'h0, te = 1'h0, pol = 1'h0;
  logic [STATE_W-1:0] st = OFF_TX_CODE;
  logic rc_s = 1'h0, rd_s = 1'h0, sd = 1'h0, ss = 1'h0, tc_s = 1'h0;
  logic ek, ed, rc, rc_oe, rd, rd_oe, tc, tc_oe, drv, cd, cv, run;
  logic [7:0] got = 8'h00;
  int n_got = 0, err_total = 0, check_count = 0;

  always #5 clock = ~clock;

  amtx_port i_dut (.clock(clock), .rst(rst), .alt_medium_enable_bit(alt),
    .tx_bitclock_gate_bit(gate), .transmit_enable_bit(te),
    .current_transmit_state_field(st), .driver_enable_polarity_in(pol),
    .recovered_clock_src(rc_s), .recovered_data_src(rd_s),
    .serial_rx_data_in(sd), .serial_rx_strobe_in(ss), .tx_bit_clock_src(tc_s),
    .ext_rx_clock_in(ek), .ext_rx_data_in(ed), .recovered_clock_out(rc),
    .recovered_clock_oe(rc_oe), .recovered_data_out(rd), .recovered_data_oe(rd_oe),
    .tx_bit_clock_out(tc), .tx_bit_clock_oe(tc_oe), .medium_driver_enable_out(drv),
    .core_rx_data(cd), .core_rx_valid(cv), .alt_path_running(run));
  amtx_pmd_model i_pmd (.link_clock(ek), .link_data(ed));

  // Collect forwarded bits, first bit ends up on top
  always @(posedge clock) begin
    if (cv === 1'h1) begin
      got <= {got[6:0], cd};
      n_got <= n_got + 1;
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic seen, input logic exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // Wait k edges, then let their updates land
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic t_reset();
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    cyc(1);
    check(rc_oe, 1'h0, "rc oe");
    check(rd_oe, 1'h0, "rd oe");
    check(cv, 1'h0, "valid");
    check(tc_oe, 1'h0, "tc oe");
  endtask

  // Recovered outputs follow alt enable, bit clock follows its gate
  task automatic t_gates(input logic en, input logic v);
    @(posedge clock);
    alt <= en;
    gate <= ~en;
    rc_s <= v;
    rd_s <= ~v;
    tc_s <= v;
    cyc(2);
    check(rc_oe, en, "rc oe");
    check(rd_oe, en, "rd oe");
    check(tc_oe, ~en, "tc oe");
    if (en) begin
      check(rc, v, "rc");
      check(rd, ~v, "rd");
      check(tc, 1'h0, "tc off");
    end else begin
      check(tc, v, "tc");
      check(rc, 1'h0, "rc off");
      check(rd, 1'h0, "rd off");
    end
  endtask

  // All enable, off/non-off state and polarity combinations; pin needs 3 edges
  task automatic t_drv();
    logic [STATE_W-1:0] s;
    for (int i = 0; i < 8; i++) begin
      s = i[1] ? ~OFF_TX_CODE : OFF_TX_CODE;
      @(posedge clock);
      te <= i[2];
      st <= s;
      pol <= i[0];
      cyc(4);
      check(drv, (i[2] && s != OFF_TX_CODE) ? i[0] : ~i[0], "drv");
    end
  endtask

  // Internal strobe reaches the core while alternate path is off
  task automatic t_strobe(input logic d);
    @(posedge clock);
    ss <= 1'h1;
    sd <= d;
    @(posedge clock);
    ss <= 1'h0;
    #1;
    check(cv, 1'h1, "strobe valid");
    check(cd, d, "strobe data");
    cyc(1);
    check(cv, 1'h0, "valid pulse");
  endtask

  // First link rise only starts the armed path; disabled path ignores the link
  task automatic t_link(input logic en, input logic [7:0] pat);
    int n0;
    @(posedge clock);
    alt <= 1'h0;
    repeat (2) @(posedge clock);
    alt <= en;
    cyc(3);
    // Count from a base so only the collector writes the counter
    n0 = n_got;
    i_pmd.send({1'h1, pat});
    for (int k = 0; k < 20 && n_got - n0 < 8; k++) cyc(1);
    check(run, en, "running");
    check(n_got - n0 == (en ? 8 : 0), 1'h1, "link count");
    for (int b = 0; b < 8 && en; b++) check(got[b], pat[b], "link bit");
  endtask

  initial begin
    t_reset();
    t_gates(1'h1, 1'h0);
    t_gates(1'h1, 1'h1);
    t_gates(1'h0, 1'h1);
    t_gates(1'h0, 1'h0);
    t_drv();
    t_strobe(1'h1);
    t_strobe(1'h0);
    t_link(1'h0, 8'hA5);
    t_link(1'h1, 8'hA5);
    t_link(1'h1, 8'h3C);
    stop_test();
  end
endmodule // amtx_port_tb
